// ---- digital_positioning_pkg.sv ----
// Purpose: Shared constants and types for the digital positioning block
// Assumes: CORE_CLK at 250 MHz, registers reached over AHB-Lite
// Notes:   Speed in 0.1 % of max output frequency, ramp times in 0.01 s

package digital_positioning_pkg;

	localparam int CLK_FREQ_MHZ = 250;

	// One ramp substep is a thousandth of 0.01 s
	localparam int RAMP_SUBSTEP_NS     = 10000;
	localparam int RAMP_SUBSTEP_CYCLES = RAMP_SUBSTEP_NS * CLK_FREQ_MHZ / 1000;
	// Hold time counts in milliseconds
	localparam int HOLD_UNIT_NS        = 1000000;
	localparam int HOLD_UNIT_CYCLES    = HOLD_UNIT_NS / 1000 * CLK_FREQ_MHZ;

	localparam logic [15:0] SPEED_FULL   = 16'h03e8;
	localparam logic [15:0] RAMP_MIN     = 16'h0001;
	localparam logic [15:0] RAMP_MAX     = 16'h7530;
	localparam logic [15:0] GEAR_MIN     = 16'h0001;

	localparam logic [15:0] MODE_RST     = 16'h0000;
	localparam logic [15:0] POSREF_RST   = 16'h0000;
	localparam logic [15:0] SPDSRC_RST   = 16'h0000;
	localparam logic [15:0] SPDPCT_RST   = 16'h00c8;
	localparam logic [15:0] ACCEL_RST    = 16'h012c;
	localparam logic [15:0] DECEL_RST    = 16'h012c;
	localparam logic [15:0] GEAR_RST     = 16'h03e8;
	localparam logic [15:0] HOLD_RST     = 16'h0064;

	localparam int BIT_CYCLE_SEL = 1;
	localparam int BIT_DONE_SEL  = 6;
	localparam int BIT_INIT_POS  = 7;
	localparam int BIT_EN_TYPE   = 8;
	localparam int BIT_POS_SRC   = 9;
	localparam int BIT_RETAIN    = 10;
	localparam int BIT_CURVE     = 12;

	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_POSREF = 8'h04;
	localparam logic [7:0] OFS_SPDSRC = 8'h08;
	localparam logic [7:0] OFS_SPDPCT = 8'h0c;
	localparam logic [7:0] OFS_ACCEL  = 8'h10;
	localparam logic [7:0] OFS_DECEL  = 8'h14;
	localparam logic [7:0] OFS_GNUM   = 8'h18;
	localparam logic [7:0] OFS_GDEN   = 8'h1c;
	localparam logic [7:0] OFS_HOLD   = 8'h20;
	localparam logic [7:0] OFS_ISTA   = 8'h24;
	localparam logic [7:0] OFS_IMASK  = 8'h28;
	localparam logic [7:0] OFS_STAT   = 8'h2c;
	localparam logic [7:0] OFS_TARGET = 8'h30;
	localparam logic [7:0] OFS_SAVED  = 8'h34;

	localparam int IRQ_START = 0;
	localparam int IRQ_DONE  = 1;
	localparam int IRQ_SAVED = 2;
	localparam int IRQ_W     = 3;

	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		SRC_DIGITAL = 3'h0,
		SRC_ANA1    = 3'h1,
		SRC_ANA2    = 3'h2,
		SRC_ANA3    = 3'h3,
		SRC_PULSE_A = 3'h4,
		SRC_PULSE_B = 3'h5
	} speed_src_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_STOP = 2'b10,
		ST_DONE = 2'b11
	} pos_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       write;
		logic       valid;
	} ahb_aphase_t;

	typedef struct packed {
		logic [15:0] analog_input_one;
		logic [15:0] analog_input_two;
		logic [15:0] analog_input_three;
		logic [15:0] fast_pulse_input_a;
		logic [15:0] fast_pulse_input_b;
	} speed_inputs_t;

endpackage : digital_positioning_pkg

// ---- digital_positioning_config.sv ----
// Purpose: Digital positioning sequencer, ramp and register file
// Assumes: Speed inputs, encoder count and target flag come from CORE_CLK logic
// Notes:   Overview of operation below
// Overview of operation
// - With the completion select bit clear the complete output lasts the hold time, else it stays on.
// - In terminal cycling the initial-positioning bit starts one move at once, clear means no initial rotation.
// - In terminal cycling the enable input is a pulse when the enable-type bit is 0 and a level when 1.
// - In automatic cycling positioning is always enabled and the enable type is ignored.
// - The target comes from the position reference register at source bit 0 and the fieldbus at 1.
// - With the retain bit set the encoder count is saved at power failure, otherwise it is not.
// - Only the straight-line profile is built, the S-curve choice is ignored.
// - The target is the 16-bit reference times the gear numerator divided by the gear denominator.
// - Speed source 0 is the digital setpoint, 1 to 3 the analog inputs, 4 and 5 the pulse inputs.
// - Speed rises from zero to full scale over the acceleration time, 0.01 s to 300.00 s, 3.00 s default.
// - Speed falls from full scale to zero over the deceleration time, 0.01 s to 300.00 s.
// - Gear numerator and denominator are 1 to 65535 and both reset to 1000.
// - Cycle select 0 gives terminal-triggered cycling, 1 gives automatic cycling.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module digital_positioning_config #(
	parameter int HOLD_UNIT_CYCLES = digital_positioning_pkg::HOLD_UNIT_CYCLES
) (
	input  wire logic                                  CORE_CLK,
	input  wire logic                                  RSTN,
	input  wire logic                                  HSEL,
	input  wire logic [31:0]                           HADDR,
	input  wire logic [1:0]                            HTRANS,
	input  wire logic                                  HWRITE,
	input  wire logic [2:0]                            HSIZE,
	input  wire logic [31:0]                           HWDATA,
	input  wire logic                                  HREADY,
	output logic      [31:0]                           HRDATA,
	output logic                                       HREADYOUT,
	output logic                                       HRESP,
	input  wire logic                                  POS_ENABLE,
	input  wire logic                                  POWER_FAIL,
	input  wire logic                                  NEAR_TARGET,
	input  wire logic [15:0]                           FIELDBUS_POS,
	input  wire logic [31:0]                           ENC_COUNT,
	input  wire digital_positioning_pkg::speed_inputs_t SPEED_INPUTS,
	output logic      [15:0]                           SPEED_CMD,
	output logic      [31:0]                           TARGET_POS,
	output logic                                       COMPLETE,
	output logic                                       SAVE_STROBE,
	output logic      [31:0]                           SAVED_COUNT,
	output logic                                       IRQ
);

	digital_positioning_pkg::pos_state_t  st_r;
	digital_positioning_pkg::ahb_aphase_t aph_r;
	logic [15:0]                          mode_r;
	logic [15:0]                          posref_r;
	logic [15:0]                          spdsrc_r;
	logic [15:0]                          spdpct_r;
	logic [15:0]                          accel_r;
	logic [15:0]                          decel_r;
	logic [15:0]                          gnum_r;
	logic [15:0]                          gden_r;
	logic [15:0]                          hold_r;
	logic [digital_positioning_pkg::IRQ_W-1:0] ista_r;
	logic [digital_positioning_pkg::IRQ_W-1:0] imask_r;
	logic [digital_positioning_pkg::IRQ_W-1:0] ev;
	logic [digital_positioning_pkg::IRQ_W-1:0] w1c;
	logic [digital_positioning_pkg::IRQ_W-1:0] ista_nxt;
	logic                                 en_s1_r, en_s2_r, en_s3_r;
	logic                                 pf_s1_r, pf_s2_r, pf_s3_r;
	logic                                 init_pend_r;
	logic [11:0]                          sub_cnt_r;
	logic [15:0]                          racc_r;
	logic [17:0]                          ms_cnt_r;
	logic [15:0]                          hold_cnt_r;
	logic                                 wr, aph_ok, auto_mode, en_rise, pf_rise;
	logic                                 trig, start, to_stop, sub_tick, ms_tick;
	logic [15:0]                          raw_spd, setpoint, goal, ramp_t, pos_src;
	logic [31:0]                          product;

	// Bus slave: zero wait states, read data prepared at the address phase
	assign aph_ok = HSEL && HTRANS[1] && HREADY;
	assign wr     = aph_r.valid && aph_r.write;

	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp16

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			digital_positioning_pkg::OFS_MODE:   rd_mux = {16'h0000, mode_r};
			digital_positioning_pkg::OFS_POSREF: rd_mux = {16'h0000, posref_r};
			digital_positioning_pkg::OFS_SPDSRC: rd_mux = {16'h0000, spdsrc_r};
			digital_positioning_pkg::OFS_SPDPCT: rd_mux = {16'h0000, spdpct_r};
			digital_positioning_pkg::OFS_ACCEL:  rd_mux = {16'h0000, accel_r};
			digital_positioning_pkg::OFS_DECEL:  rd_mux = {16'h0000, decel_r};
			digital_positioning_pkg::OFS_GNUM:   rd_mux = {16'h0000, gnum_r};
			digital_positioning_pkg::OFS_GDEN:   rd_mux = {16'h0000, gden_r};
			digital_positioning_pkg::OFS_HOLD:   rd_mux = {16'h0000, hold_r};
			digital_positioning_pkg::OFS_ISTA:   rd_mux = {29'h0, ista_r};
			digital_positioning_pkg::OFS_IMASK:  rd_mux = {29'h0, imask_r};
			digital_positioning_pkg::OFS_STAT:   rd_mux = {SPEED_CMD, 13'h0, COMPLETE, st_r};
			digital_positioning_pkg::OFS_TARGET: rd_mux = TARGET_POS;
			digital_positioning_pkg::OFS_SAVED:  rd_mux = SAVED_COUNT;
			default:                             rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			aph_r     <= '0;
			HRDATA    <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			aph_r.valid <= aph_ok && (HADDR[31:8] == 24'h0) && (HSIZE == digital_positioning_pkg::HSIZE_WORD);
			aph_r.write <= HWRITE;
			aph_r.addr  <= HADDR[7:0];
			HRDATA      <= (aph_ok && !HWRITE && HADDR[31:8] == 24'h0) ? rd_mux(HADDR[7:0]) : 32'h0;
		end
	end

	// Configuration registers; out-of-range ramp-time and gear writes are clamped into range
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_r   <= digital_positioning_pkg::MODE_RST;
			posref_r <= digital_positioning_pkg::POSREF_RST;
			spdsrc_r <= digital_positioning_pkg::SPDSRC_RST;
			spdpct_r <= digital_positioning_pkg::SPDPCT_RST;
			accel_r  <= digital_positioning_pkg::ACCEL_RST;
			decel_r  <= digital_positioning_pkg::DECEL_RST;
			gnum_r   <= digital_positioning_pkg::GEAR_RST;
			gden_r   <= digital_positioning_pkg::GEAR_RST;
			hold_r   <= digital_positioning_pkg::HOLD_RST;
			imask_r  <= '0;
		end else if (wr) begin
			case (aph_r.addr)
				digital_positioning_pkg::OFS_MODE:   mode_r   <= HWDATA[15:0];
				digital_positioning_pkg::OFS_POSREF: posref_r <= HWDATA[15:0];
				digital_positioning_pkg::OFS_SPDSRC: spdsrc_r <= HWDATA[15:0];
				digital_positioning_pkg::OFS_SPDPCT: spdpct_r <= HWDATA[15:0];
				digital_positioning_pkg::OFS_ACCEL:  accel_r  <= clamp16(HWDATA[15:0],
					digital_positioning_pkg::RAMP_MIN, digital_positioning_pkg::RAMP_MAX);
				digital_positioning_pkg::OFS_DECEL:  decel_r  <= clamp16(HWDATA[15:0],
					digital_positioning_pkg::RAMP_MIN, digital_positioning_pkg::RAMP_MAX);
				digital_positioning_pkg::OFS_GNUM:   gnum_r   <= clamp16(HWDATA[15:0],
					digital_positioning_pkg::GEAR_MIN, 16'hffff);
				digital_positioning_pkg::OFS_GDEN:   gden_r   <= clamp16(HWDATA[15:0],
					digital_positioning_pkg::GEAR_MIN, 16'hffff);
				digital_positioning_pkg::OFS_HOLD:   hold_r   <= HWDATA[15:0];
				digital_positioning_pkg::OFS_IMASK:  imask_r  <= HWDATA[digital_positioning_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Pin synchronisers; the second stage feeds logic, the third only the edge detectors
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			{en_s1_r, en_s2_r, en_s3_r} <= 3'h0;
			{pf_s1_r, pf_s2_r, pf_s3_r} <= 3'h0;
		end else begin
			en_s1_r <= POS_ENABLE;
			en_s2_r <= en_s1_r;
			en_s3_r <= en_s2_r;
			pf_s1_r <= POWER_FAIL;
			pf_s2_r <= pf_s1_r;
			pf_s3_r <= pf_s2_r;
		end
	end

	assign en_rise   = en_s2_r && !en_s3_r;
	assign pf_rise   = pf_s2_r && !pf_s3_r;
	assign auto_mode = mode_r[digital_positioning_pkg::BIT_CYCLE_SEL];

	// Trigger: automatic mode needs nothing, terminal mode pulse or level
	always_comb begin
		if (auto_mode) begin
			trig = 1'b1;
		end else if (init_pend_r && mode_r[digital_positioning_pkg::BIT_INIT_POS]) begin
			trig = 1'b1;
		end else if (mode_r[digital_positioning_pkg::BIT_EN_TYPE]) begin
			trig = en_s2_r;
		end else begin
			trig = en_rise;
		end
	end

	assign start   = (st_r == digital_positioning_pkg::ST_IDLE) && trig;
	assign to_stop = NEAR_TARGET || (!auto_mode && mode_r[digital_positioning_pkg::BIT_EN_TYPE]
		&& !en_s2_r);

	// Initial move is re-armed by each write of the mode word
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			init_pend_r <= 1'b0;
		end else if (start) begin
			init_pend_r <= 1'b0;
		end else if (wr && aph_r.addr == digital_positioning_pkg::OFS_MODE) begin
			init_pend_r <= 1'b1;
		end else if (st_r == digital_positioning_pkg::ST_IDLE
			&& !mode_r[digital_positioning_pkg::BIT_INIT_POS]) begin
			init_pend_r <= 1'b0;
		end
	end

	// Speed source; out-of-list codes fall back to the digital setpoint
	always_comb begin
		case (digital_positioning_pkg::speed_src_t'(spdsrc_r[2:0]))
			digital_positioning_pkg::SRC_ANA1:    raw_spd = SPEED_INPUTS.analog_input_one;
			digital_positioning_pkg::SRC_ANA2:    raw_spd = SPEED_INPUTS.analog_input_two;
			digital_positioning_pkg::SRC_ANA3:    raw_spd = SPEED_INPUTS.analog_input_three;
			digital_positioning_pkg::SRC_PULSE_A: raw_spd = SPEED_INPUTS.fast_pulse_input_a;
			digital_positioning_pkg::SRC_PULSE_B: raw_spd = SPEED_INPUTS.fast_pulse_input_b;
			default:                              raw_spd = spdpct_r;
		endcase
		if (spdsrc_r[15:3] != 13'h0) begin
			raw_spd = spdpct_r;
		end
		setpoint = (raw_spd > digital_positioning_pkg::SPEED_FULL)
			? digital_positioning_pkg::SPEED_FULL : raw_spd;
		goal     = (st_r == digital_positioning_pkg::ST_RUN) ? setpoint : 16'h0000;
		ramp_t   = (goal > SPEED_CMD) ? accel_r : decel_r;
	end

	// Ramp substep divider
	assign sub_tick = (sub_cnt_r == 12'(digital_positioning_pkg::RAMP_SUBSTEP_CYCLES - 1));

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sub_cnt_r <= 12'h000;
		end else begin
			sub_cnt_r <= sub_tick ? 12'h000 : sub_cnt_r + 12'h001;
		end
	end

	// One unit step per ramp-time substeps gives a full-scale sweep in the ramp time.
	// Straight line only: the curve select bit is deliberately not read.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SPEED_CMD <= 16'h0000;
			racc_r    <= 16'h0000;
		end else if (sub_tick) begin
			if (SPEED_CMD == goal) begin
				racc_r <= 16'h0000;
			end else if (racc_r + 16'h0001 >= ramp_t) begin
				racc_r    <= 16'h0000;
				SPEED_CMD <= (goal > SPEED_CMD) ? SPEED_CMD + 16'h0001 : SPEED_CMD - 16'h0001;
			end else begin
				racc_r <= racc_r + 16'h0001;
			end
		end
	end

	// Target position through the electronic gear
	assign pos_src = mode_r[digital_positioning_pkg::BIT_POS_SRC] ? FIELDBUS_POS : posref_r;
	assign product = pos_src * gnum_r;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			TARGET_POS <= 32'h0;
		end else begin
			TARGET_POS <= product / {16'h0000, gden_r};
		end
	end

	// Millisecond divider runs only while dwelling, so the hold is exact
	assign ms_tick = (ms_cnt_r == 18'(HOLD_UNIT_CYCLES - 1));

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ms_cnt_r   <= 18'h0;
			hold_cnt_r <= 16'h0000;
		end else if (st_r != digital_positioning_pkg::ST_DONE) begin
			ms_cnt_r   <= 18'h0;
			hold_cnt_r <= 16'h0000;
		end else if (ms_tick) begin
			ms_cnt_r   <= 18'h0;
			hold_cnt_r <= hold_cnt_r + 16'h0001;
		end else begin
			ms_cnt_r <= ms_cnt_r + 18'h1;
		end
	end

	// Sequencer
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r     <= digital_positioning_pkg::ST_IDLE;
			COMPLETE <= 1'b0;
		end else begin
			case (st_r)
				digital_positioning_pkg::ST_IDLE: begin
					if (start) begin
						st_r     <= digital_positioning_pkg::ST_RUN;
						COMPLETE <= 1'b0;
					end
				end
				digital_positioning_pkg::ST_RUN: begin
					if (to_stop) begin
						st_r <= digital_positioning_pkg::ST_STOP;
					end
				end
				digital_positioning_pkg::ST_STOP: begin
					if (SPEED_CMD == 16'h0000) begin
						st_r     <= digital_positioning_pkg::ST_DONE;
						COMPLETE <= 1'b1;
					end
				end
				digital_positioning_pkg::ST_DONE: begin
					if (hold_cnt_r >= hold_r) begin
						st_r <= digital_positioning_pkg::ST_IDLE;
						if (!mode_r[digital_positioning_pkg::BIT_DONE_SEL]) begin
							COMPLETE <= 1'b0;
						end
					end
				end
				default: st_r <= digital_positioning_pkg::ST_IDLE;
			endcase
		end
	end

	// Encoder count retention at power loss
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SAVE_STROBE <= 1'b0;
			SAVED_COUNT <= 32'h0;
		end else begin
			SAVE_STROBE <= pf_rise && mode_r[digital_positioning_pkg::BIT_RETAIN];
			if (pf_rise && mode_r[digital_positioning_pkg::BIT_RETAIN]) begin
				SAVED_COUNT <= ENC_COUNT;
			end
		end
	end

	// Interrupt status: a new event wins over a same-cycle clear
	assign ev[digital_positioning_pkg::IRQ_START] = start;
	assign ev[digital_positioning_pkg::IRQ_DONE]  = (st_r == digital_positioning_pkg::ST_STOP)
		&& (SPEED_CMD == 16'h0000);
	assign ev[digital_positioning_pkg::IRQ_SAVED] = pf_rise && mode_r[digital_positioning_pkg::BIT_RETAIN];
	assign w1c      = (wr && aph_r.addr == digital_positioning_pkg::OFS_ISTA)
		? HWDATA[digital_positioning_pkg::IRQ_W-1:0] : '0;
	assign ista_nxt = (ista_r & ~w1c) | ev;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ista_r <= '0;
			IRQ    <= 1'b0;
		end else begin
			ista_r <= ista_nxt;
			IRQ    <= |(ista_r & imask_r);
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_stop_done;
		st_r == digital_positioning_pkg::ST_STOP && SPEED_CMD == 16'h0000;
	endsequence

	sequence s_done_exit;
		st_r == digital_positioning_pkg::ST_DONE && hold_cnt_r >= hold_r;
	endsequence

	a_hold_drop: assert property (s_done_exit and !mode_r[6] |=> !COMPLETE)
		else $error("Complete output not dropped after hold time");
	a_always_valid: assert property (s_done_exit and mode_r[6] |=> COMPLETE)
		else $error("Complete output dropped in always-valid mode");
	a_complete_rise: assert property (s_stop_done |=> COMPLETE && st_r == digital_positioning_pkg::ST_DONE)
		else $error("Completion not flagged at standstill");
	a_no_initial: assert property (st_r == digital_positioning_pkg::ST_IDLE && !auto_mode
		&& !mode_r[7] && !en_s2_r && !en_s3_r |=> st_r == digital_positioning_pkg::ST_IDLE)
		else $error("Move started without trigger");
	a_pulse_start: assert property (st_r == digital_positioning_pkg::ST_IDLE && !auto_mode
		&& !mode_r[8] && $rose(en_s2_r) |=> st_r == digital_positioning_pkg::ST_RUN)
		else $error("Enable edge did not start a move");
	a_level_start: assert property (st_r == digital_positioning_pkg::ST_IDLE && !auto_mode
		&& mode_r[8] && en_s2_r |=> st_r == digital_positioning_pkg::ST_RUN)
		else $error("Enable level did not start a move");
	a_auto_start: assert property (st_r == digital_positioning_pkg::ST_IDLE && auto_mode
		|=> st_r == digital_positioning_pkg::ST_RUN)
		else $error("Automatic cycling did not restart");
	a_gear_target: assert property (##1 TARGET_POS == $past(product) / {16'h0000, $past(gden_r)})
		else $error("Target position does not follow the gear ratio");
	a_save_count: assert property ($rose(pf_s2_r) && mode_r[10] |=> SAVE_STROBE
		&& SAVED_COUNT == $past(ENC_COUNT) ##1 !SAVE_STROBE)
		else $error("Encoder count not saved at power failure");
	a_no_save: assert property ($rose(pf_s2_r) && !mode_r[10] |=> !SAVE_STROBE
		&& $stable(SAVED_COUNT))
		else $error("Encoder count saved with retain off");
	a_ramp_step: assert property (##1 (SPEED_CMD - $past(SPEED_CMD) <= 16'h0001
		|| $past(SPEED_CMD) - SPEED_CMD <= 16'h0001))
		else $error("Speed jumped by more than one step");
	a_accel_rate: assert property (sub_tick && goal > SPEED_CMD && racc_r + 16'h0001 >= accel_r
		|=> SPEED_CMD == $past(SPEED_CMD) + 16'h0001)
		else $error("Acceleration step missed");
	a_decel_rate: assert property (sub_tick && goal < SPEED_CMD && racc_r + 16'h0001 < decel_r
		|=> SPEED_CMD == $past(SPEED_CMD))
		else $error("Deceleration stepped early");
	a_gear_range: assert property (gnum_r != 16'h0000 && gden_r != 16'h0000)
		else $error("Gear ratio term out of range");

endmodule : digital_positioning_config

`default_nettype wire

// ---- motor_encoder_model.sv ----
// Purpose: Motor and encoder stand-in for the positioning block
// Assumes: Speed command in 0.1 % units of max output frequency
// Notes:   Count grows by the speed each cycle, decel asked at target
`timescale 1ns/1ps
`default_nettype none
module motor_encoder_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [15:0] speed,
	input  wire logic [31:0] target,
	output logic      [31:0] enc,
	output logic             near
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			enc <= '0;
		else
			enc <= enc + {16'h0000, speed};
	end
	// Crude travel model, enough to end one move
	assign near = (enc >= target);
endmodule : motor_encoder_model
`default_nettype wire

// ---- digital_positioning_config_tb.sv ----
// Purpose: Self-checking bench for the positioning block
// Assumes: Bus never waits for ever, one move fits the run
// Notes:   Short hold unit keeps the completion dwell brief
`timescale 1ns/1ps
`default_nettype none
module digital_positioning_config_tb;
	logic clk, rstn, hsel, hwrite, pe, pf, rdph;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, q[$], sq[$];
	logic [15:0] fb, peak, r;
	digital_positioning_pkg::speed_inputs_t si;
	wire logic [31:0] hrdata, target, saved, enc;
	wire logic [15:0] speed;
	wire logic hready, hresp, complete, strobe, irq, near;
	int mismatches, checked, cyc, n;
	digital_positioning_config #(.HOLD_UNIT_CYCLES(10)) dut (.CORE_CLK(clk), .RSTN(rstn),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.POS_ENABLE(pe), .POWER_FAIL(pf), .NEAR_TARGET(near), .FIELDBUS_POS(fb),
		.ENC_COUNT(enc), .SPEED_INPUTS(si), .SPEED_CMD(speed), .TARGET_POS(target),
		.COMPLETE(complete), .SAVE_STROBE(strobe), .SAVED_COUNT(saved), .IRQ(irq));
	motor_encoder_model partner (.clk(clk), .rstn(rstn), .speed(speed), .target(target),
		.enc(enc), .near(near));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	// Read passes expected data in d, write passes the value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		if (!w)
			q.push_back(d);
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rdph <= !w;
		do @(posedge clk); while (hready !== 1'b1);
		rdph <= 1'b0;
		hsel <= 1'b0;
	endtask : xfer
	always @(posedge clk) begin
		if (rdph === 1'b1) begin
			chk(hrdata, q.pop_front());
			chk({31'h0, hresp}, 32'h0);
		end
		if (strobe === 1'b1)
			chk(saved, (sq.size() > 0) ? sq.pop_front() : ~saved);
		if (speed > peak)
			peak <= speed;
		cyc++;
		if (cyc == 100000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		{hsel, hwrite, pe, pf, rdph, htrans, haddr, hwdata, peak} = '0;
		rstn = 1'b0;
		r = 16'($urandom(24090));
		fb = 16'($urandom);
		// Distinct per source, so a wrong source choice shows in the peak
		si = {16'h0001, 16'h0002, 16'h0007, 16'($urandom % 4 + 3), 16'h0008};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		xfer(0, digital_positioning_pkg::OFS_GNUM, 32'h3e8);
		xfer(0, digital_positioning_pkg::OFS_GDEN, 32'h3e8);
		xfer(0, digital_positioning_pkg::OFS_ACCEL, 32'h12c);
		xfer(0, digital_positioning_pkg::OFS_MODE, 32'h0);
		xfer(0, 8'h3c, 32'h0);
		$display("end reset values");
		r = 16'($urandom);
		xfer(1, digital_positioning_pkg::OFS_GNUM, 32'h3);
		xfer(1, digital_positioning_pkg::OFS_GDEN, 32'h7);
		xfer(1, digital_positioning_pkg::OFS_POSREF, {16'h0, r});
		xfer(0, digital_positioning_pkg::OFS_TARGET, r * 32'd3 / 32'd7);
		xfer(1, digital_positioning_pkg::OFS_MODE, 32'h200);
		xfer(0, digital_positioning_pkg::OFS_TARGET, fb * 32'd3 / 32'd7);
		$display("end gear scaling");
		xfer(1, digital_positioning_pkg::OFS_MODE, 32'h1000);
		xfer(1, digital_positioning_pkg::OFS_POSREF, 32'hea60);
		for (n = 0; n < 7; n++)
			xfer(1, 8'(8'h08 + 4 * n), (n == 0) ? 32'h4 : (n == 6) ? 32'h2 : 32'h1);
		xfer(1, digital_positioning_pkg::OFS_IMASK, 32'h2);
		pe <= 1'b1;
		repeat (4) @(posedge clk);
		pe <= 1'b0;
		while (complete !== 1'b1)
			@(posedge clk);
		chk(peak, si.fast_pulse_input_a);
		n = 0;
		while (complete === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 20 && n <= 23, 1'b1);
		chk(irq, 1'b1);
		xfer(0, digital_positioning_pkg::OFS_ISTA, 32'h3);
		xfer(1, digital_positioning_pkg::OFS_ISTA, 32'h7);
		xfer(0, digital_positioning_pkg::OFS_ISTA, 32'h0);
		chk(irq, 1'b0);
		$display("end pulse move");
		xfer(1, digital_positioning_pkg::OFS_GDEN, 32'h0);
		xfer(0, digital_positioning_pkg::OFS_GDEN, 32'h1);
		// Huge target keeps the next moves clear of the near flag
		xfer(1, digital_positioning_pkg::OFS_GNUM, 32'hffff);
		xfer(0, digital_positioning_pkg::OFS_TARGET, 32'hea60 * 32'hffff);
		chk(target, 32'hea60 * 32'hffff);
		xfer(1, digital_positioning_pkg::OFS_MODE, 32'h1c0);
		repeat (6000) @(posedge clk);
		chk(complete, 1'b1);
		xfer(0, digital_positioning_pkg::OFS_ISTA, 32'h3);
		xfer(1, digital_positioning_pkg::OFS_ISTA, 32'h7);
		pe <= 1'b1;
		repeat (3000) @(posedge clk);
		chk(complete, 1'b0);
		chk(speed != 16'h0, 1'b1);
		pe <= 1'b0;
		while (complete !== 1'b1)
			@(posedge clk);
		repeat (100) @(posedge clk);
		chk(complete, 1'b1);
		chk(speed, 16'h0);
		$display("end level move");
		xfer(1, digital_positioning_pkg::OFS_MODE, 32'h142);
		repeat (3000) @(posedge clk);
		chk(speed != 16'h0, 1'b1);
		xfer(1, digital_positioning_pkg::OFS_MODE, 32'h100);
		while (complete !== 1'b1)
			@(posedge clk);
		$display("end auto move");
		for (n = 0; n < 2; n++) begin
			xfer(1, digital_positioning_pkg::OFS_MODE, n ? 32'h400 : 32'h0);
			if (n)
				sq.push_back(enc);
			pf <= 1'b1;
			repeat (6) @(posedge clk);
			pf <= 1'b0;
			repeat (4) @(posedge clk);
		end
		chk(sq.size(), 0);
		$display("end power fail");
		results();
	end
endmodule : digital_positioning_config_tb
`default_nettype wire
